// ===== rtl/pes_pkg.sv
// ****************************************************************
// Shared constants for the port ackID and error status block.
// ****************************************************************
package pes_pkg;

  // Register byte addresses on the Wishbone bus.
  localparam logic [11:0] PES_ACKID_OFS  = 12'h148;
  localparam logic [11:0] PES_STATUS_OFS = 12'h158;

  // Field positions, counted with bit 0 as the least significant.
  localparam int PES_ACK_W       = 5;
  localparam int PES_ACK_LSB     = 0;
  localparam int PES_OUTST_LSB   = 8;
  localparam int PES_DROP_BIT    = 26;
  localparam int PES_FAIL_BIT    = 25;
  localparam int PES_DEG_BIT     = 24;
  localparam int PES_RE_BIT      = 20;
  localparam int PES_RS_BIT      = 18;
  localparam int PES_OK_BIT      = 1;
  localparam int PES_UNINIT_BIT  = 0;

  // Sticky flag slots inside the flag vector.
  localparam int PES_NFLAG  = 4;
  localparam int PES_F_DROP = 0;
  localparam int PES_F_FAIL = 1;
  localparam int PES_F_DEG  = 2;
  localparam int PES_F_RE   = 3;

  // Reset values and the fixed powered-down answer.
  localparam logic [31:0] PES_STATUS_RST = 32'h00000001;
  localparam logic [31:0] PES_PWRDN_VAL  = 32'h00000001;
  localparam logic [4:0]  PES_ACKID_RST  = 5'h00;

  // Time to process an ackID write, and its cycle count at 50 MHz.
  localparam int PES_CLK_MHZ   = 50;
  localparam int PES_APPLY_NS  = 40;
  localparam int PES_APPLY_CYC =
    ((PES_APPLY_NS * PES_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (PES_APPLY_NS * PES_CLK_MHZ + 999) / 1000;

  // States of the ackID write processing.
  typedef enum logic [1:0]
  {
    PES_IDLE = 2'b01,
    PES_PEND = 2'b10
  } pes_ack_state_t;

endpackage

// ===== rtl/pes_sticky.sv
`timescale 1ns/1ns
// ****************************************************************
// Sticky flags: set by hardware events, cleared by writing a one.
// ****************************************************************
module pes_sticky
  import pes_pkg::*;
#(
  parameter int N = 4
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flag_o
);

  typedef struct packed
  {
    logic [N-1:0] flag;
  } pes_sticky_t;

  pes_sticky_t  st_r;
  pes_sticky_t  st_nxt;
  logic [N-1:0] flag_nxt;

  // Each flag keeps its value; a set in the clearing cycle wins.
  for (genvar i = 0; i < N; i++)
  begin : g_flag
    assign flag_nxt[i] = set_i[i] | (st_r.flag[i] & ~clr_i[i]);
  end

  // Next state of the flag vector.
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.flag = flag_nxt;
  end

  // Flags clear on reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flag_o = st_r.flag;

endmodule

// ===== rtl/pes_ackid.sv
`timescale 1ns/1ns
// ****************************************************************
// Outbound ackID counter with software-forced restart.
// ****************************************************************
module pes_ackid
  import pes_pkg::*;
#(
  parameter int APPLY_CYC = PES_APPLY_CYC
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wr_i,
  input  wire logic [PES_ACK_W-1:0] wdata_i,
  input  wire logic                 abort_i,
  input  wire logic                 sent_i,
  input  wire logic                 acked_i,
  output logic      [PES_ACK_W-1:0] next_o,
  output logic      [PES_ACK_W-1:0] outst_o,
  output logic                      retx_o,
  output logic                      busy_o
);

  typedef struct packed
  {
    pes_ack_state_t       st;
    logic [PES_ACK_W-1:0] next_id;
    logic [PES_ACK_W-1:0] outst;
    logic [PES_ACK_W-1:0] wval;
    logic [7:0]           cnt;
    logic                 retx;
  } pes_ackid_t;

  pes_ackid_t st_r;
  pes_ackid_t st_nxt;

  // Counts sent and acknowledged packets and applies pending writes.
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.retx = 1'b0;
    if (sent_i)
      st_nxt.next_id = st_r.next_id + 5'h01;
    if (acked_i)
      st_nxt.outst = st_r.outst + 5'h01;
    case (st_r.st)
      PES_IDLE:
      begin
        if (wr_i)
        begin
          st_nxt.st   = PES_PEND;
          st_nxt.wval = wdata_i;
          st_nxt.cnt  = 8'(APPLY_CYC - 1);
        end
      end
      PES_PEND:
      begin
        if (wr_i)
        begin
          // A newer write restarts processing with its own value.
          st_nxt.wval = wdata_i;
          st_nxt.cnt  = 8'(APPLY_CYC - 1);
        end
        else if (abort_i)
          st_nxt.st = PES_IDLE; // [RULE3]
        else if (st_r.cnt == 8'h00)
        begin
          // Applied in any port state, normal or error.
          st_nxt.st      = PES_IDLE; // [RULE4]
          st_nxt.next_id = st_r.wval; // [RULE2]
          st_nxt.outst   = st_r.wval;
          st_nxt.retx    = 1'b1; // [RULE2]
        end
        else
          st_nxt.cnt = st_r.cnt - 8'h01;
      end
      default:
        st_nxt.st = PES_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r         <= '0;
      st_r.st      <= PES_IDLE;
      st_r.next_id <= PES_ACKID_RST;
      st_r.outst   <= PES_ACKID_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign next_o  = st_r.next_id; // [RULE1]
  assign outst_o = st_r.outst;
  assign retx_o  = st_r.retx;
  assign busy_o  = (st_r.st == PES_PEND);

endmodule

// ===== rtl/pes_top.sv
`timescale 1ns/1ns
// Contract
// [RULE1] Hold next transmit ackID in bits 27 to 31 of ackID status; the code holds it in bits 0 to 4.
// [RULE2] Software write of next ackID restarts retransmission from it.
// [RULE3] Inbound error or retry during write processing discards the write.
// [RULE4] A written ackID applies in normal and in error port states.
// [RULE5] Software writes ackID only with an idle queue and quiet link.
// [RULE6] Status reads return 0x0000001 while the port is powered down.
// [RULE7] Set dropped flag on threshold drop, time-to-live or transfer error.
// [RULE8] Set failed flag when failed-port threshold is reached.
// [RULE9] Set degraded flag when degraded-port threshold is reached.
// [RULE10] Set retry-encountered flag when retry-halted becomes set.
// [RULE11] Flags clear by writing one; zero keeps; reserved read zero.
// [RULE12] Not-initialized set after reset, exclusive with link-up.
// [RULE13] Retry-halted shows output retry-stopped state.
module pes_top
  import pes_pkg::*;
#(
  parameter int APPLY_CYC = PES_APPLY_CYC
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [11:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 retry_stopped_i,
  input  wire logic                 link_up_i,
  input  wire logic                 powered_down_i,
  input  wire logic                 err_thresh_i,
  input  wire logic                 drop_en_i,
  input  wire logic                 ttl_expired_i,
  input  wire logic                 transfer_error_ack_i,
  input  wire logic                 mac_transfer_error_i,
  input  wire logic                 fail_thresh_i,
  input  wire logic                 deg_thresh_i,
  input  wire logic                 inbound_abort_i,
  input  wire logic                 pkt_sent_i,
  input  wire logic                 pkt_acked_i,
  output logic      [PES_ACK_W-1:0] next_tx_ackid_o,
  output logic                      retransmit_o,
  output logic                      ackid_busy_o
);

  // ****************************************************************
  // State record
  // ****************************************************************

  typedef struct packed
  {
    logic        ack;
    logic [31:0] dat;
    logic        rs_prev;
    logic        halted;
    logic        link_up;
  } pes_top_t;

  pes_top_t st_r;
  pes_top_t st_nxt;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  logic       req;
  logic       wr_en;
  logic       hit_ack;
  logic       hit_sts;
  logic [3:0] wsel;

  // A request is a live cycle with strobe; ack follows one cycle later.
  assign req     = wb_cyc_i & wb_stb_i;
  assign hit_ack = (wb_adr_i[11:2] == PES_ACKID_OFS[11:2]);
  assign hit_sts = (wb_adr_i[11:2] == PES_STATUS_OFS[11:2]);

  // Writes take effect on the edge at which the master sees ack.
  assign wr_en = req & wb_we_i & st_r.ack;
  assign wsel  = wr_en ? wb_sel_i : 4'h0;

  // ****************************************************************
  // AckID tracking
  // ****************************************************************

  logic                 ack_wr;
  logic [PES_ACK_W-1:0] next_id;
  logic [PES_ACK_W-1:0] outst_id;
  logic                 retx;
  logic                 busy;

  // The ackID field lives in the lowest byte lane.
  assign ack_wr = hit_ack & wsel[0]; // [RULE2]

  // Software is trusted to write only on a quiet link.
  pes_ackid #(
    .APPLY_CYC (APPLY_CYC)
  ) u_ackid (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (ack_wr),
    .wdata_i (wb_dat_i[PES_ACK_LSB +: PES_ACK_W]), // [RULE5]
    .abort_i (inbound_abort_i), // [RULE3]
    .sent_i  (pkt_sent_i),
    .acked_i (pkt_acked_i),
    .next_o  (next_id),
    .outst_o (outst_id),
    .retx_o  (retx),
    .busy_o  (busy)
  );

  // ****************************************************************
  // Sticky flags
  // ****************************************************************

  logic [PES_NFLAG-1:0] fset;
  logic [PES_NFLAG-1:0] fclr;
  logic [PES_NFLAG-1:0] flags;
  logic                 drop_evt;

  // Any of the discard causes marks a dropped packet.
  assign drop_evt = (err_thresh_i & drop_en_i)
                  | ttl_expired_i
                  | transfer_error_ack_i
                  | mac_transfer_error_i; // [RULE7]

  // Event sources for each flag.
  always_comb
  begin
    fset             = '0;
    fset[PES_F_DROP] = drop_evt; // [RULE7]
    fset[PES_F_FAIL] = fail_thresh_i; // [RULE8]
    fset[PES_F_DEG]  = deg_thresh_i; // [RULE9]
    fset[PES_F_RE]   = retry_stopped_i & ~st_r.rs_prev; // [RULE10]
  end

  // Writing a one clears a flag; a zero leaves it alone.
  always_comb
  begin
    fclr             = '0;
    if (hit_sts)
    begin
      fclr[PES_F_DROP] = wsel[3] & wb_dat_i[PES_DROP_BIT]; // [RULE11]
      fclr[PES_F_FAIL] = wsel[3] & wb_dat_i[PES_FAIL_BIT]; // [RULE11]
      fclr[PES_F_DEG]  = wsel[3] & wb_dat_i[PES_DEG_BIT]; // [RULE11]
      fclr[PES_F_RE]   = wsel[2] & wb_dat_i[PES_RE_BIT]; // [RULE11]
    end
  end

  pes_sticky #(
    .N (PES_NFLAG)
  ) u_sticky (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (fset),
    .clr_i  (fclr),
    .flag_o (flags)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic [31:0] ackid_word;
  logic [31:0] status_word;
  logic [31:0] rdata;

  // AckID register view; reserved bits read as zero.
  always_comb
  begin
    ackid_word = '0;
    ackid_word[PES_ACK_LSB +: PES_ACK_W]   = next_id; // [RULE1]
    ackid_word[PES_OUTST_LSB +: PES_ACK_W] = outst_id;
  end

  // Live status view; reserved bits read as zero.
  always_comb
  begin
    status_word = '0; // [RULE11]
    status_word[PES_DROP_BIT]   = flags[PES_F_DROP];
    status_word[PES_FAIL_BIT]   = flags[PES_F_FAIL];
    status_word[PES_DEG_BIT]    = flags[PES_F_DEG];
    status_word[PES_RE_BIT]     = flags[PES_F_RE];
    status_word[PES_RS_BIT]     = st_r.halted; // [RULE13]
    status_word[PES_OK_BIT]     = st_r.link_up; // [RULE12]
    status_word[PES_UNINIT_BIT] = ~st_r.link_up; // [RULE12]
  end

  // Address decode; unmapped addresses read zero and still ack.
  always_comb
  begin
    if (hit_ack)
      rdata = ackid_word;
    else if (hit_sts && powered_down_i)
      rdata = PES_PWRDN_VAL; // [RULE6]
    else if (hit_sts)
      rdata = status_word;
    else
      rdata = '0;
  end

  // ****************************************************************
  // State update
  // ****************************************************************

  // Ack pulses once per request; read data is caught with it.
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.ack     = req & ~st_r.ack;
    st_nxt.rs_prev = retry_stopped_i;
    st_nxt.halted  = retry_stopped_i; // [RULE13]
    st_nxt.link_up = link_up_i;
    if (req && !st_r.ack)
      st_nxt.dat = rdata;
  end

  // Reset leaves the link marked not initialized.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r     <= '0;
      st_r.dat <= '0; // [RULE12]
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign wb_ack_o        = st_r.ack;
  assign wb_dat_o        = st_r.dat;
  assign next_tx_ackid_o = next_id; // [RULE1]
  assign retransmit_o    = retx; // [RULE2]
  assign ackid_busy_o    = busy;

endmodule

// ===== bench/pes_top_asserts.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks for the ackID and error status block.
// ****************************************************************
module pes_top_chk
  import pes_pkg::*;
#(
  parameter int APPLY_CYC = PES_APPLY_CYC
)
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [11:0]          wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 powered_down_i,
  input wire logic                 inbound_abort_i,
  input wire logic [PES_ACK_W-1:0] next_tx_ackid_o,
  input wire logic                 retransmit_o,
  input wire logic                 ackid_busy_o
);
  logic [PES_ACK_W-1:0] wval_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Keeps the ackID of the last accepted write for comparison.
  always_ff @(posedge clk_i)
  begin
    if (wb_ack_o && wb_we_i && wb_adr_i == PES_ACKID_OFS && wb_sel_i[0])
      wval_r <= wb_dat_i[PES_ACK_W-1:0];
  end

  // Accepted ackID write and status read.
  sequence wr_take;
    wb_ack_o && wb_we_i && wb_adr_i == PES_ACKID_OFS && wb_sel_i[0];
  endsequence
  sequence st_read;
    wb_ack_o && !wb_we_i && wb_adr_i == PES_STATUS_OFS;
  endsequence

  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pwrdn_read_a: assert property (st_read and (powered_down_i &&
    $past(powered_down_i)) |-> wb_dat_o == PES_PWRDN_VAL)
    else $error("powered down status wrong");
  link_excl_a: assert property (st_read |-> wb_dat_o[1] != wb_dat_o[0])
    else $error("link flags not exclusive");
  wr_busy_a: assert property (wr_take |=> ackid_busy_o)
    else $error("ackID write not pending");
  wr_resolve_a: assert property (wr_take |->
    ##[1:8] (retransmit_o || inbound_abort_i))
    else $error("ackID write never applied");
  retx_val_a: assert property (retransmit_o |-> next_tx_ackid_o == wval_r)
    else $error("retransmit with wrong ackID");
  abort_drop_a: assert property (ackid_busy_o && inbound_abort_i &&
    !wb_ack_o |=> !ackid_busy_o && !retransmit_o)
    else $error("aborted write still applied");
  rsvd_zero_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == PES_ACKID_OFS |-> wb_dat_o[31:13] == 0 && wb_dat_o[7:5] == 0)
    else $error("reserved ackID bits not zero");
endmodule

bind pes_top pes_top_chk #(.APPLY_CYC(APPLY_CYC)) chk (.*);

// ===== bench/pes_link_partner.sv
`timescale 1ns/1ns
// ****************************************************************
// Link partner: brings the link up, sends and acknowledges packets.
// ****************************************************************
module pes_link_partner
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic traffic_i,
  input  wire logic retry_i,
  output logic      link_up_o,
  output logic      retry_stopped_o,
  output logic      pkt_sent_o,
  output logic      pkt_acked_o
);
  logic [3:0] cnt_r;

  // Link rises some cycles after reset; packets flow only when allowed.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 4'h0;
      link_up_o <= 1'b0;
      pkt_sent_o <= 1'b0;
      pkt_acked_o <= 1'b0;
      retry_stopped_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      link_up_o <= link_up_o | (cnt_r == 4'h7);
      pkt_sent_o <= traffic_i && cnt_r[1:0] == 2'h0;
      pkt_acked_o <= pkt_sent_o;
      retry_stopped_o <= retry_i;
    end
  end
endmodule

// ===== bench/test_pes_top.sv
`timescale 1ns/1ns
// ****************************************************************
// Self-checking bench for the ackID and error status block.
// ****************************************************************
module test_pes_top
  import pes_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [5:0]  ev = 6'h00;
  logic        pd = 1'b0;
  logic        dropen = 1'b0;
  logic        abort = 1'b0;
  logic        traffic = 1'b0;
  logic        rs_req = 1'b0;
  logic        ack, lup, rstop, sent, acked, retx, busy;
  logic [31:0] dout;
  logic [31:0] w;
  logic [4:0]  cur, nxt;
  int          err_count = 0;
  int          n_tests = 0;
  int          n_retx = 0;
  int          cycles = 0;
  int          seed = 94;
  int          i, nr;

  pes_top #(.APPLY_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .retry_stopped_i(rstop), .link_up_i(lup), .powered_down_i(pd),
    .err_thresh_i(ev[0]), .drop_en_i(dropen), .ttl_expired_i(ev[1]),
    .transfer_error_ack_i(ev[2]), .mac_transfer_error_i(ev[3]),
    .fail_thresh_i(ev[4]), .deg_thresh_i(ev[5]),
    .inbound_abort_i(abort), .pkt_sent_i(sent), .pkt_acked_i(acked),
    .next_tx_ackid_o(nxt), .retransmit_o(retx), .ackid_busy_o(busy));

  pes_link_partner far (.clk_i(clk_i), .rst_i(rst_i),
    .traffic_i(traffic), .retry_i(rs_req), .link_up_o(lup),
    .retry_stopped_o(rstop), .pkt_sent_o(sent), .pkt_acked_o(acked));

  // Clock, retransmit counter and hang guard.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    n_retx += (retx === 1'b1);
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // Bus cycle, comparison and verdict helpers.
  task xfer(input logic w_i, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w_i;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task print_verdict();
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] flag_of(input int k);
    return (k == 0) ? 32'h0 : (k < 5) ? 32'h0400_0000 :
           (k == 5) ? 32'h0200_0000 : 32'h0100_0000;
  endfunction

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PES_STATUS_OFS, PES_STATUS_RST);
    rd(PES_ACKID_OFS, 32'h0);
    traffic <= 1'b1;
    repeat (10) @(posedge clk_i);
    for (i = 0; i < 7; i++)
    begin
      dropen <= (i != 0);
      @(posedge clk_i);
      ev <= 6'h01 << ((i == 0) ? 0 : i - 1);
      @(posedge clk_i);
      ev <= 6'h00;
      rd(PES_STATUS_OFS, 32'h2 | flag_of(i));
      xfer(1'b1, PES_STATUS_OFS, $random(seed) & ~32'h0710_0000);
      sel <= 4'h3;
      xfer(1'b1, PES_STATUS_OFS, 32'h0710_0000);
      sel <= 4'hF;
      rd(PES_STATUS_OFS, 32'h2 | flag_of(i));
      xfer(1'b1, PES_STATUS_OFS, 32'h0710_0000);
      rd(PES_STATUS_OFS, 32'h2);
    end
    rs_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(PES_STATUS_OFS, 32'h0014_0002);
    rs_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(PES_STATUS_OFS, 32'h0010_0002);
    traffic <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 4; i++)
    begin
      w = $random(seed);
      rs_req <= (i == 3);
      nr = n_retx;
      xfer(1'b1, PES_ACKID_OFS, w);
      abort <= (i == 2);
      do @(posedge clk_i); while (busy !== 1'b0);
      abort <= 1'b0;
      @(posedge clk_i);
      if (i != 2)
        cur = w[4:0];
      chk(n_retx - nr, (i != 2));
      chk({27'h0, nxt}, {27'h0, cur});
      rd(PES_ACKID_OFS, {19'h0, cur, 3'h0, cur});
    end
    rs_req <= 1'b0;
    pd <= 1'b1;
    rd(PES_STATUS_OFS, PES_PWRDN_VAL);
    pd <= 1'b0;
    xfer(1'b1, 12'h200, $random(seed));
    rd(12'h200, 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PES_STATUS_OFS, PES_STATUS_RST);
    print_verdict();
  end
endmodule
